// ### hub_port_defs.vh
// register map, field positions, reset values and timing counts
`ifndef HUB_PORT_DEFS_VH
`define HUB_PORT_DEFS_VH

`define ADDR_W 8
`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define MASK_ADDR 8'h08
`define STATE_ADDR 8'h0C

`define CTRL_PWR_LSB 0
`define CTRL_PWR_MSB 3
`define CTRL_SUSPEND_BIT 4
`define CTRL_RESET 5'h00

`define STAT_OC_LSB 0
`define STAT_OC_MSB 3
`define STAT_CLKLOSS_BIT 4
`define STATUS_RESET 5'h00
`define MASK_RESET 5'h00

`define STATE_OC_LSB 0
`define STATE_GANGED_BIT 4
`define STATE_RATE_BIT 5
`define STATE_CLKOK_BIT 6
`define STATE_EXTDIS_BIT 7

`define CLK_PERIOD_NS 10
`define OC_FILTER_NS 1000
`define OC_FILTER_CYCLES ((`OC_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_WATCH_NS 2000
`define CLK_WATCH_CYCLES (`CLK_WATCH_NS / `CLK_PERIOD_NS)

`endif

// ### overcurrent_filter.v
// synchroniser and glitch filter for one active-low overcurrent pin
`timescale 1ns/1ns
`default_nettype none
`include "hub_port_defs.vh"

module overcurrent_filter (
	input wire clk,
	input wire rst,
	input wire pin_n,
	output wire active
);

	localparam integer FILTER_CYCLES = `OC_FILTER_CYCLES;
	localparam [7:0] FILTER_LAST = FILTER_CYCLES[7:0] - 8'h01;

	reg sync1_q;
	reg sync2_q;
	reg active_q;
	reg [7:0] count_q;
	wire sample;

	assign sample = ~sync2_q;
	assign active = active_q;

	always @(posedge clk)
	begin
		if (rst)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			active_q <= 1'b0;
			count_q <= 8'h00;
		end
		else
		begin
			sync1_q <= pin_n;
			sync2_q <= sync1_q;
			// level must hold for the whole window before it is believed
			if (sample == active_q)
				count_q <= 8'h00;
			else if (count_q == FILTER_LAST)
			begin
				active_q <= sample;
				count_q <= 8'h00;
			end
			else
				count_q <= count_q + 8'h01;
		end
	end

endmodule // overcurrent_filter
`default_nettype wire

// ### hub_port_power_clock_ctrl.v
// port power, overcurrent, suspend and clock-source control with APB regs
//
// Contract
// - per-port mode: four separate overcurrent inputs, each judged on its own.
// - shared mode: any sense input counts; board ties all inputs together.
// - overcurrent inputs are active low and noise filtered before use.
// - power outputs are active-low push-pull: low means power on.
// - reset initialises all internal logic; system asserts it at power up.
// - suspend status output is high in suspend, low in normal operation.
// - rate select low picks 6 MHz crystal, high picks 48 MHz clock.
// - crystal mode uses the internal PLL to make 48 and 12 MHz clocks.
// - with external memory disabled, shared select picks the mode; static.
`timescale 1ns/1ns
`default_nettype none
`include "hub_port_defs.vh"

module hub_port_power_clock_ctrl (
	input wire CLOCK,
	input wire RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	input wire PORT1_OVERCURRENT_N,
	input wire PORT2_OVERCURRENT_N,
	input wire PORT3_OVERCURRENT_N,
	input wire PORT4_OVERCURRENT_N,
	output wire PORT1_POWER_EN_N,
	output wire PORT2_POWER_EN_N,
	output wire PORT3_POWER_EN_N,
	output wire PORT4_POWER_EN_N,
	output wire SUSPEND_STATUS,
	input wire CLOCK_RATE_SELECT,
	input wire FAST_CLOCK_IN,
	input wire CRYSTAL_IN,
	input wire EXT_MEMORY_DISABLE,
	input wire SHARED_POWER_SELECT,
	output wire PLL_ENABLE,
	output wire FAST_CLOCK_SELECT,
	output wire IRQ
);

	localparam integer WATCH_CYCLES = `CLK_WATCH_CYCLES;
	localparam [7:0] WATCH_LAST = WATCH_CYCLES[7:0] - 8'h01;

	// bus state
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;

	// registers
	reg [4:0] ctrl_q;
	reg [4:0] ctrl_d;
	reg [4:0] status_q;
	reg [4:0] status_d;
	reg [4:0] mask_q;
	reg [4:0] mask_d;

	// pin outputs
	reg [3:0] power_n_q;
	reg suspend_q;
	reg pll_en_q;
	reg fast_sel_q;
	reg irq_q;

	// strap synchronisers and captured straps
	reg rate_s1_q;
	reg rate_s2_q;
	reg extdis_s1_q;
	reg extdis_s2_q;
	reg shared_s1_q;
	reg shared_s2_q;
	reg extdis_s3_q;
	reg [1:0] settle_q;
	reg straps_taken_q;
	reg rate_q;
	reg extdis_q;
	reg ganged_q;

	// clock activity monitor
	reg xtal_s1_q;
	reg xtal_s2_q;
	reg xtal_s3_q;
	reg fast_s1_q;
	reg fast_s2_q;
	reg fast_s3_q;
	reg [7:0] watch_q;
	reg clk_ok_q;

	// overcurrent
	wire [3:0] oc_pin_n;
	wire [3:0] oc_active;
	reg [3:0] oc_prev_q;
	wire [3:0] oc_rise;
	wire [3:0] oc_cut;
	wire oc_any;

	// bus decode, selected clock edge and clock loss
	wire setup_phase;
	wire access_phase;
	wire wr_en;
	wire wr_ctrl;
	wire wr_mask;
	wire rd_status;
	wire addr_hit;
	wire sel_edge;
	wire clk_loss;

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign PORT1_POWER_EN_N = power_n_q[0];
	assign PORT2_POWER_EN_N = power_n_q[1];
	assign PORT3_POWER_EN_N = power_n_q[2];
	assign PORT4_POWER_EN_N = power_n_q[3];
	assign SUSPEND_STATUS = suspend_q;
	assign PLL_ENABLE = pll_en_q;
	assign FAST_CLOCK_SELECT = fast_sel_q;
	assign IRQ = irq_q;

	assign oc_pin_n = {PORT4_OVERCURRENT_N, PORT3_OVERCURRENT_N,
		PORT2_OVERCURRENT_N, PORT1_OVERCURRENT_N};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_port
			overcurrent_filter u_filter (
				.clk(CLOCK),
				.rst(RST),
				.pin_n(oc_pin_n[gi]),
				.active(oc_active[gi])
			);
		end
	endgenerate

	assign oc_rise = oc_active & ~oc_prev_q;
	assign oc_any = |oc_active;
	// shared mode cuts every port on any input, else only the port itself
	assign oc_cut = ganged_q ? {4{oc_any}} : oc_active;

	assign setup_phase = PSEL & ~PENABLE;
	assign access_phase = PSEL & PENABLE & pready_q;
	assign addr_hit = (PADDR == `CTRL_ADDR) | (PADDR == `STATUS_ADDR) |
		(PADDR == `MASK_ADDR) | (PADDR == `STATE_ADDR);
	assign wr_en = access_phase & PWRITE & addr_hit;
	assign wr_ctrl = wr_en & (PADDR == `CTRL_ADDR);
	assign wr_mask = wr_en & (PADDR == `MASK_ADDR);
	assign rd_status = access_phase & ~PWRITE & (PADDR == `STATUS_ADDR);

	// straps are sampled once after reset and then treated as static
	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			rate_s1_q <= 1'b0;
			rate_s2_q <= 1'b0;
			extdis_s1_q <= 1'b0;
			extdis_s2_q <= 1'b0;
			shared_s1_q <= 1'b0;
			shared_s2_q <= 1'b0;
			extdis_s3_q <= 1'b0;
			settle_q <= 2'h0;
			straps_taken_q <= 1'b0;
			rate_q <= 1'b0;
			extdis_q <= 1'b0;
			ganged_q <= 1'b0;
		end
		else
		begin
			rate_s1_q <= CLOCK_RATE_SELECT;
			rate_s2_q <= rate_s1_q;
			extdis_s1_q <= EXT_MEMORY_DISABLE;
			extdis_s2_q <= extdis_s1_q;
			shared_s1_q <= SHARED_POWER_SELECT;
			shared_s2_q <= shared_s1_q;
			extdis_s3_q <= extdis_s2_q;
			// synchronisers show reset levels for the first edges
			if (settle_q != 2'h3)
				settle_q <= settle_q + 2'h1;
			// take straps only once the real memory-disable pin level has stood two edges
			if (!straps_taken_q && settle_q == 2'h3 &&
				extdis_s2_q == extdis_s3_q)
			begin
				straps_taken_q <= 1'b1;
				rate_q <= rate_s2_q;
				extdis_q <= extdis_s2_q;
				// shared pin doubles as memory data when memory is enabled
				ganged_q <= extdis_s2_q & shared_s2_q;
			end
		end
	end

	// clock source selection and activity monitor of the selected source
	assign sel_edge = rate_q ? (fast_s2_q ^ fast_s3_q) :
		(xtal_s2_q ^ xtal_s3_q);
	assign clk_loss = clk_ok_q & (watch_q == WATCH_LAST);

	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			xtal_s1_q <= 1'b0;
			xtal_s2_q <= 1'b0;
			xtal_s3_q <= 1'b0;
			fast_s1_q <= 1'b0;
			fast_s2_q <= 1'b0;
			fast_s3_q <= 1'b0;
			watch_q <= 8'h00;
			clk_ok_q <= 1'b0;
			pll_en_q <= 1'b0;
			fast_sel_q <= 1'b0;
		end
		else
		begin
			xtal_s1_q <= CRYSTAL_IN;
			xtal_s2_q <= xtal_s1_q;
			xtal_s3_q <= xtal_s2_q;
			fast_s1_q <= FAST_CLOCK_IN;
			fast_s2_q <= fast_s1_q;
			fast_s3_q <= fast_s2_q;
			pll_en_q <= straps_taken_q & ~rate_q;
			fast_sel_q <= straps_taken_q & rate_q;
			// the 48 MHz source is sampled near its limit, so the watchdog
			// only proves presence, not frequency
			if (sel_edge)
			begin
				watch_q <= 8'h00;
				clk_ok_q <= 1'b1;
			end
			else if (watch_q == WATCH_LAST)
				clk_ok_q <= 1'b0;
			else
				watch_q <= watch_q + 8'h01;
		end
	end

	// control register next value; overcurrent outranks a software enable
	always @*
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = PWDATA[4:0];
		ctrl_d[`CTRL_PWR_MSB:`CTRL_PWR_LSB] =
			ctrl_d[`CTRL_PWR_MSB:`CTRL_PWR_LSB] & ~oc_cut;
	end

	// status: read clears, a new event in the same cycle is kept
	always @*
	begin
		status_d = status_q;
		if (rd_status)
			status_d = `STATUS_RESET;
		status_d[`STAT_OC_MSB:`STAT_OC_LSB] =
			status_d[`STAT_OC_MSB:`STAT_OC_LSB] | oc_rise;
		if (clk_loss)
			status_d[`STAT_CLKLOSS_BIT] = 1'b1;
	end

	// mask next value, so a mask write reaches the interrupt at once
	always @*
	begin
		mask_d = mask_q;
		if (wr_mask)
			mask_d = PWDATA[4:0];
	end

	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			ctrl_q <= `CTRL_RESET;
			status_q <= `STATUS_RESET;
			mask_q <= `MASK_RESET;
			oc_prev_q <= 4'h0;
			power_n_q <= 4'hF;
			suspend_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			oc_prev_q <= oc_active;
			mask_q <= mask_d;
			// push-pull active-low: a one here turns the port off
			power_n_q <= ~(ctrl_d[`CTRL_PWR_MSB:`CTRL_PWR_LSB] &
				~oc_cut);
			suspend_q <= ctrl_d[`CTRL_SUSPEND_BIT];
			// level follows the status and mask of this same edge
			irq_q <= |(status_d & mask_d);
		end
	end

	// apb slave: no wait states, data registered during setup
	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (setup_phase)
		begin
			pready_q <= 1'b1;
			pslverr_q <= ~addr_hit;
			prdata_q <= 32'h0000_0000;
			if (!PWRITE)
			begin
				case (PADDR)
					`CTRL_ADDR:
						prdata_q <= {27'h000_0000, ctrl_q};
					`STATUS_ADDR:
						prdata_q <= {27'h000_0000, status_q};
					`MASK_ADDR:
						prdata_q <= {27'h000_0000, mask_q};
					`STATE_ADDR:
						prdata_q <= {24'h00_0000, extdis_q, clk_ok_q,
							rate_q, ganged_q, oc_active};
					default:
						prdata_q <= 32'h0000_0000;
				endcase
			end
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
	end

endmodule // hub_port_power_clock_ctrl
`default_nettype wire

// ### port_power_monitor.sv
// assertion checker for the port power and clock control block
`timescale 1ns/1ns
`default_nettype none
module port_power_monitor (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic PORT1_OVERCURRENT_N,
	input wire logic PORT1_POWER_EN_N,
	input wire logic SUSPEND_STATUS,
	input wire logic CLOCK_RATE_SELECT,
	input wire logic PLL_ENABLE,
	input wire logic FAST_CLOCK_SELECT,
	input wire logic IRQ
);
	logic [7:0] low_q;
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	// cycles the port 1 pin has stayed low, saturating
	always_ff @(posedge CLOCK)
		if (RST || PORT1_OVERCURRENT_N)
			low_q <= 8'h00;
		else if (low_q != 8'hff)
			low_q <= low_q + 8'h01;
	AST_RESET_INIT: assert property ($fell(RST) |-> PORT1_POWER_EN_N
		&& !SUSPEND_STATUS && !IRQ && !PREADY) else $error("reset values");
	AST_READY_ONE: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready");
	AST_READY_IDLE: assert property (!PSEL |-> !PREADY) else $error("ready");
	AST_ERR_ACCESS: assert property (PSLVERR |-> PREADY && PENABLE)
		else $error("slverr");
	AST_RDATA_QUIET: assert property (!PREADY || PWRITE |-> PRDATA == '0)
		else $error("rdata");
	AST_OC_OFF: assert property (low_q == 8'h6e |-> PORT1_POWER_EN_N)
		else $error("port stays on");
	// a slow filter still passes; anything near the spike length fails
	AST_OFF_CAUSE: assert property ($rose(PORT1_POWER_EN_N) |->
		$past(PENABLE && PWRITE) || low_q > 8'h5a) else $error("off");
	AST_ON_CAUSE: assert property ($fell(PORT1_POWER_EN_N) |->
		$past(PENABLE && PWRITE && PWDATA[0])) else $error("on");
	AST_SUSP_CAUSE: assert property ($changed(SUSPEND_STATUS) |->
		$past(PENABLE && PWRITE)) else $error("suspend");
	AST_CLK_SOURCE: assert property (PLL_ENABLE || FAST_CLOCK_SELECT |->
		PLL_ENABLE != FAST_CLOCK_SELECT && FAST_CLOCK_SELECT == CLOCK_RATE_SELECT)
		else $error("clock source");
endmodule // port_power_monitor
bind hub_port_power_clock_ctrl port_power_monitor i_mon (.CLOCK, .RST, .PSEL,
	.PENABLE, .PWRITE, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
	.PORT1_OVERCURRENT_N, .PORT1_POWER_EN_N, .SUSPEND_STATUS,
	.CLOCK_RATE_SELECT, .PLL_ENABLE, .FAST_CLOCK_SELECT, .IRQ);
`default_nettype wire

// ### port_switch_model.sv
// power switches, overcurrent detectors and clock sources on the board
`timescale 1ns/1ns
`default_nettype none
module port_switch_model (
	input wire logic shared,
	input wire logic rate,
	input wire logic [3:0] fault,
	input wire logic stop,
	output logic [3:0] overcurrent_n,
	output logic crystal,
	output logic fast
);
	initial crystal = 1'b0;
	initial fast = 1'b0;
	// 6 MHz only in crystal mode; the fast clock is rounded to whole ns
	// both run through reset; stop freezes the fast one to show a loss
	always #83 crystal = !rate && !crystal;
	always #10 fast = rate && !stop && !fast;
	// ganged boards tie every sense pin together
	assign overcurrent_n = shared ? {4{~|fault}} : ~fault;
endmodule // port_switch_model
`default_nettype wire

// ### hub_port_power_clock_ctrl_tb.sv
// self-checking bench for the port power and clock control block
`timescale 1ns/1ns
`default_nettype none
`include "hub_port_defs.vh"
`define CHK(n, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("[FAIL] %s exp %h got %h", n, e, g); \
		end \
	end
module hub_port_power_clock_ctrl_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0;
	logic [3:0] fault = 4'h0;
	logic rate = 1'b0;
	logic shared_sel = 1'b0;
	logic stop = 1'b0;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int total_checks = 0;
	wire [31:0] prdata;
	wire [3:0] oc_n;
	wire [3:0] pwr_n;
	wire pready, pslverr, susp, pll, fast_sel, irq, xtal, fast_clk;
	always #5 clock = ~clock;
	port_switch_model i_far (.shared(shared_sel), .rate(rate), .fault(fault),
		.stop(stop), .overcurrent_n(oc_n), .crystal(xtal), .fast(fast_clk));
	hub_port_power_clock_ctrl i_dut (.CLOCK(clock), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PORT1_OVERCURRENT_N(oc_n[0]), .PORT2_OVERCURRENT_N(oc_n[1]),
		.PORT3_OVERCURRENT_N(oc_n[2]), .PORT4_OVERCURRENT_N(oc_n[3]),
		.PORT1_POWER_EN_N(pwr_n[0]), .PORT2_POWER_EN_N(pwr_n[1]),
		.PORT3_POWER_EN_N(pwr_n[2]), .PORT4_POWER_EN_N(pwr_n[3]),
		.SUSPEND_STATUS(susp), .CLOCK_RATE_SELECT(rate),
		.FAST_CLOCK_IN(fast_clk), .CRYSTAL_IN(xtal), .EXT_MEMORY_DISABLE(1'b1),
		.SHARED_POWER_SELECT(shared_sel), .PLL_ENABLE(pll),
		.FAST_CLOCK_SELECT(fast_sel), .IRQ(irq));
	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic restart;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
	initial
	begin
		#50000;
		failures++;
		report_and_stop();
	end
	initial
	begin
		restart();
		`CHK("reset power", 4'hf, pwr_n)
		`CHK("pll", 2'b01, {fast_sel, pll})
		apb(1'b0, 8'h10, '0);
		`CHK("unmapped", 33'h1_0000_0000, {err, rd})
		apb(1'b1, `CTRL_ADDR, 32'h1f);
		`CHK("power on", 5'h10, {susp, pwr_n})
		apb(1'b1, `CTRL_ADDR, 32'h0f);
		`CHK("resume", 1'b0, susp)
		apb(1'b1, `MASK_ADDR, 32'h1f);
		fault <= 4'h2;
		repeat (50) @(posedge clock);
		fault <= 4'h0;
		repeat (120) @(posedge clock);
		`CHK("spike", 4'h0, pwr_n)
		apb(1'b0, `STATE_ADDR, '0);
		`CHK("state", 4'hc, rd[7:4])
		fault <= 4'h4;
		repeat (120) @(posedge clock);
		`CHK("one off", 5'h14, {irq, pwr_n})
		apb(1'b0, `STATUS_ADDR, '0);
		`CHK("status", 33'h0_0000_0004, {irq, rd})
		apb(1'b0, `STATUS_ADDR, '0);
		`CHK("cleared", 32'h0, rd)
		fault <= 4'h0;
		repeat (120) @(posedge clock);
		apb(1'b1, `CTRL_ADDR, 32'h0f);
		`CHK("re-enable", 4'h0, pwr_n)
		rst <= 1'b1;
		rate <= 1'b1;
		shared_sel <= 1'b1;
		restart();
		`CHK("fast", 2'b10, {fast_sel, pll})
		apb(1'b1, `CTRL_ADDR, 32'h0f);
		fault <= 4'h1;
		repeat (120) @(posedge clock);
		`CHK("all off", 5'h0f, {irq, pwr_n})
		apb(1'b0, `STATUS_ADDR, '0);
		`CHK("shared status", 32'h0f, rd)
		apb(1'b0, `STATE_ADDR, '0);
		`CHK("shared state", 4'hf, rd[7:4])
		apb(1'b1, `MASK_ADDR, 32'h10);
		stop <= 1'b1;
		repeat (220) @(posedge clock);
		`CHK("clock lost", 1'b1, irq)
		apb(1'b0, `STATUS_ADDR, '0);
		`CHK("loss status", 32'h10, rd)
		apb(1'b0, `STATE_ADDR, '0);
		`CHK("loss state", 1'b0, rd[6])
		report_and_stop();
	end
endmodule // hub_port_power_clock_ctrl_tb
`default_nettype wire
